// *** include/stepper_pkg.sv ***
`default_nettype none
package stepper_pkg;

  // Phase position: eight half-step positions, full step uses every other one
  localparam int          POS_WIDTH       = 3;
  localparam logic [2:0]  POS_RESET       = 3'h0;
  localparam logic [2:0]  POS_STEP_FULL   = 3'h2;
  localparam logic [2:0]  POS_STEP_HALF   = 3'h1;

  // Winding pattern bit positions in {w2_rev, w2_fwd, w1_rev, w1_fwd}
  localparam int          W1_FWD_BIT      = 0;
  localparam int          W1_REV_BIT      = 1;
  localparam int          W2_FWD_BIT      = 2;
  localparam int          W2_REV_BIT      = 3;
  localparam logic [3:0]  WINDINGS_OFF    = 4'h0;

  // Clock rate and host timing
  localparam int          CLK_HZ          = 20000000;
  localparam int          CLEAR_WAIT_NS   = 10000;
  localparam int          PULSE_MIN_NS    = 10000;
  localparam int          DIR_HOLD_NS     = 6250;
  localparam int          MODE_HOLD_NS    = 5000;
  localparam int          CLEAR_WAIT_CYC  = (CLEAR_WAIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          PULSE_MIN_CYC   = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          DIR_HOLD_CYC    = (DIR_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          MODE_HOLD_CYC   = (MODE_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          POR_HOLD_CYC    = 4;
  // Step edges still issued, each later than the last, once run drops
  localparam int          RAMP_EDGES      = 4;
  localparam int          TIMER_WIDTH     = 16;

  // Ordered half-step pattern, position 0 = winding1_fwd with winding2_rev
  function automatic logic [3:0] pattern_at(input logic [2:0] pos);
    logic [3:0] p;
    p = WINDINGS_OFF;
    unique case (pos)
      3'h0: p = 4'h9;
      3'h1: p = 4'h1;
      3'h2: p = 4'h5;
      3'h3: p = 4'h4;
      3'h4: p = 4'h6;
      3'h5: p = 4'h2;
      3'h6: p = 4'ha;
      3'h7: p = 4'h8;
    endcase
    return p;
  endfunction : pattern_at

endpackage : stepper_pkg
`default_nettype wire

// *** include/stepper_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface stepper_if;
  logic step_clock;
  logic excitation_select;
  logic edge_select;
  logic direction_select;
  logic sequencer_clear_n;
  logic enable;
  logic winding1_fwd;
  logic winding1_rev;
  logic winding2_fwd;
  logic winding2_rev;
  logic protection_alarm_n;

  modport device (
    input  step_clock, excitation_select, edge_select, direction_select,
    input  sequencer_clear_n, enable,
    output winding1_fwd, winding1_rev, winding2_fwd, winding2_rev, protection_alarm_n
  );
  modport host (
    output step_clock, excitation_select, edge_select, direction_select,
    output sequencer_clear_n, enable,
    input  winding1_fwd, winding1_rev, winding2_fwd, winding2_rev, protection_alarm_n
  );
endinterface : stepper_if
`default_nettype wire

// *** verilog/stepper_phase_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_sequencer (
  input  wire logic clk,
  input  wire logic reset_n,
  stepper_if.device link,
  input  wire logic overcurrent_detect,
  input  wire logic overheat_detect,
  output logic      fault_latched
);
  import stepper_pkg::*;

  // Three-stage synchronisers; a change counts once stages two and three agree
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;
  logic [NSYNC-1:0] stable_reg;

  assign raw_in = {overheat_detect, overcurrent_detect, link.enable, link.sequencer_clear_n,
                   link.direction_select, link.edge_select, link.step_clock};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[g]  <= 1'b0;
          sync2_reg[g]  <= 1'b0;
          sync3_reg[g]  <= 1'b0;
          stable_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= raw_in[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            stable_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Excitation select goes through its own synchroniser to keep indices simple
  logic exc_s1_reg;
  logic exc_s2_reg;
  logic exc_s3_reg;
  logic exc_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_s1_reg <= 1'b0;
      exc_s2_reg <= 1'b0;
      exc_s3_reg <= 1'b0;
      exc_reg    <= 1'b0;
    end else begin
      exc_s1_reg <= link.excitation_select;
      exc_s2_reg <= exc_s1_reg;
      exc_s3_reg <= exc_s2_reg;
      if (exc_s2_reg == exc_s3_reg) begin
        exc_reg <= exc_s3_reg;
      end
    end
  end

  logic step_s;
  logic edge_s;
  logic dir_s;
  logic clear_n_s;
  logic enable_s;
  logic fault_s;
  assign step_s    = stable_reg[0];
  assign edge_s    = stable_reg[1];
  assign dir_s     = stable_reg[2];
  assign clear_n_s = stable_reg[3];
  assign enable_s  = stable_reg[4];
  assign fault_s   = stable_reg[5] | stable_reg[6];

  // Power-on reset: hold the sequencer cleared for a few cycles after reset release
  logic [2:0] por_cnt_reg;
  logic       por_done_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt_reg  <= 3'h0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg <= 3'(por_cnt_reg + 3'h1);
      if (por_cnt_reg == 3'(POR_HOLD_CYC - 1)) begin
        por_done_reg <= 1'b1;
      end
    end
  end

  logic seq_clear;
  assign seq_clear = !clear_n_s || !por_done_reg;

  // Step edge detection on the filtered step clock
  logic step_prev_reg;
  logic step_event;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= step_s;
    end
  end
  // Rising only when edge select is high, both edges otherwise
  assign step_event = edge_s ? (step_s && !step_prev_reg)
                             : (step_s != step_prev_reg);

  // Position advance: counted while disabled too, so timing continues
  logic [POS_WIDTH-1:0] pos_reg;
  logic [POS_WIDTH-1:0] pos_next;
  logic [POS_WIDTH-1:0] stride;
  always_comb begin
    stride = exc_reg ? POS_STEP_HALF : POS_STEP_FULL;
    pos_next = pos_reg;
    if (exc_reg) begin
      pos_next = dir_s ? 3'(pos_reg - stride) : 3'(pos_reg + stride);
    end else begin
      // From an odd (single-winding) position, full step lands on the next even one
      if (pos_reg[0]) begin
        pos_next = dir_s ? 3'(pos_reg - 3'h1) : 3'(pos_reg + 3'h1);
      end else begin
        pos_next = dir_s ? 3'(pos_reg - stride) : 3'(pos_reg + stride);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_reg <= POS_RESET;
    end else if (seq_clear) begin
      pos_reg <= POS_RESET;
    end else if (step_event) begin
      pos_reg <= pos_next;
    end
  end

  // Fault latch: set wins over clear; only power-on or clear pulse releases it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_latched <= 1'b0;
    end else if (fault_s) begin
      fault_latched <= 1'b1;
    end else if (seq_clear) begin
      fault_latched <= 1'b0;
    end
  end

  // Outputs registered; off while disabled or faulted
  logic [3:0] pattern;
  assign pattern = pattern_at(pos_reg);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.winding1_fwd       <= 1'b0;
      link.winding1_rev       <= 1'b0;
      link.winding2_fwd       <= 1'b0;
      link.winding2_rev       <= 1'b0;
      link.protection_alarm_n <= 1'b1;
    end else begin
      link.protection_alarm_n <= !(fault_latched || fault_s);
      if (!enable_s || fault_latched || fault_s) begin
        link.winding1_fwd <= 1'b0;
        link.winding1_rev <= 1'b0;
        link.winding2_fwd <= 1'b0;
        link.winding2_rev <= 1'b0;
      end else begin
        link.winding1_fwd <= pattern[W1_FWD_BIT];
        link.winding1_rev <= pattern[W1_REV_BIT];
        link.winding2_fwd <= pattern[W2_FWD_BIT];
        link.winding2_rev <= pattern[W2_REV_BIT];
      end
    end
  end

endmodule : stepper_phase_sequencer
`default_nettype wire

// *** verilog/stepper_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module stepper_host #(
  parameter int HALF_PERIOD_CYC = 400
) (
  input  wire logic clk,
  input  wire logic reset_n,
  stepper_if.host   link,
  input  wire logic run,
  input  wire logic half_step,
  input  wire logic both_edges,
  input  wire logic reverse,
  input  wire logic power_good,
  input  wire logic clear_request,
  output logic      busy,
  output logic      alarm
);
  import stepper_pkg::*;

  // The longest run-out half period must still fit the timer
  generate
    if (HALF_PERIOD_CYC < PULSE_MIN_CYC || RAMP_EDGES > 7 ||
        HALF_PERIOD_CYC * (RAMP_EDGES + 2) / 2 >= (1 << TIMER_WIDTH)) begin : g_bad_period
      $error("HALF_PERIOD_CYC out of range");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_CLEAR = 3'h1,
    ST_WAIT  = 3'h2,
    ST_RUN   = 3'h4
  } host_state_e;

  host_state_e             state_reg;
  logic [TIMER_WIDTH-1:0]  timer_reg;
  logic [TIMER_WIDTH-1:0]  limit_reg;
  logic [2:0]              ramp_reg;
  logic                    alarm_s1_reg;
  logic                    alarm_s2_reg;
  logic                    alarm_s3_reg;

  // Mode lines change only in the low phase, at least MODE_HOLD_CYC + DIR_HOLD_CYC cycles after the falling edge
  logic settled;
  assign settled = (timer_reg >= TIMER_WIDTH'(MODE_HOLD_CYC + DIR_HOLD_CYC));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg              <= ST_CLEAR;
      timer_reg              <= '0;
      limit_reg              <= TIMER_WIDTH'(HALF_PERIOD_CYC - 1);
      ramp_reg               <= 3'h0;
      link.step_clock        <= 1'b0;
      link.sequencer_clear_n <= 1'b0;
      link.excitation_select <= 1'b0;
      link.edge_select       <= 1'b1;
      link.direction_select  <= 1'b0;
      busy                   <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_CLEAR: begin
          link.sequencer_clear_n <= 1'b0;
          link.step_clock        <= 1'b0;
          timer_reg              <= '0;
          limit_reg              <= TIMER_WIDTH'(HALF_PERIOD_CYC - 1);
          ramp_reg               <= 3'h0;
          busy                   <= 1'b1;
          if (!clear_request) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          link.sequencer_clear_n <= 1'b1;
          timer_reg <= TIMER_WIDTH'(timer_reg + 1'b1);
          if (clear_request) begin
            state_reg <= ST_CLEAR;
          end else if (timer_reg >= TIMER_WIDTH'(CLEAR_WAIT_CYC)) begin
            state_reg <= ST_RUN;
            timer_reg <= '0;
            busy      <= 1'b0;
          end
        end
        ST_RUN: begin
          if (clear_request) begin
            state_reg <= ST_CLEAR;
          end else begin
            timer_reg <= TIMER_WIDTH'(timer_reg + 1'b1);
            if (!link.step_clock && settled) begin
              link.excitation_select <= half_step;
              link.edge_select       <= !both_edges;
              link.direction_select  <= reverse;
            end
            if (run) begin
              limit_reg <= TIMER_WIDTH'(HALF_PERIOD_CYC - 1);
              ramp_reg  <= 3'(RAMP_EDGES);
            end
            if ((run || ramp_reg != 3'h0) && timer_reg >= limit_reg) begin
              link.step_clock <= !link.step_clock;
              timer_reg       <= '0;
              if (!run) begin
                // A sudden stop lets inertia carry the shaft past the target
                limit_reg <= TIMER_WIDTH'(limit_reg + TIMER_WIDTH'(HALF_PERIOD_CYC / 2));
                ramp_reg  <= 3'(ramp_reg - 3'h1);
              end
            end
          end
        end
        default: state_reg <= ST_CLEAR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.enable <= 1'b0;
    end else begin
      link.enable <= power_good && state_reg == ST_RUN;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_s1_reg <= 1'b0;
      alarm_s2_reg <= 1'b0;
      alarm_s3_reg <= 1'b0;
      alarm        <= 1'b0;
    end else begin
      alarm_s1_reg <= !link.protection_alarm_n;
      alarm_s2_reg <= alarm_s1_reg;
      alarm_s3_reg <= alarm_s2_reg;
      if (alarm_s2_reg == alarm_s3_reg) begin
        alarm <= alarm_s3_reg;
      end
    end
  end

endmodule : stepper_host
`default_nettype wire

// *** testbench/stepper_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module stepper_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step_clock,
  input wire logic excitation_select,
  input wire logic edge_select,
  input wire logic direction_select,
  input wire logic sequencer_clear_n,
  input wire logic enable,
  input wire logic winding1_fwd,
  input wire logic winding1_rev,
  input wire logic winding2_fwd,
  input wire logic winding2_rev,
  input wire logic protection_alarm_n
);
  logic [3:0] wind;
  assign wind = {winding2_rev, winding2_fwd, winding1_rev, winding1_fwd};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Set by a clear long enough to pass the input filter, dropped by the next step edge
  logic fresh_reg;
  logic clear_prev_reg;
  logic step_prev_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fresh_reg      <= 1'b0;
      clear_prev_reg <= 1'b1;
      step_prev_reg  <= 1'b0;
    end else begin
      clear_prev_reg <= sequencer_clear_n;
      step_prev_reg  <= step_clock;
      if (!sequencer_clear_n && !clear_prev_reg) begin
        fresh_reg <= 1'b1;
      end else if (step_clock != step_prev_reg) begin
        fresh_reg <= 1'b0;
      end
    end
  end

  chk_off_disabled: assert property ((!enable) [*8] |-> wind == 4'h0)
    else $error("windings driven while disabled");
  chk_off_alarm: assert property ((!protection_alarm_n) [*3] |-> wind == 4'h0)
    else $error("windings driven during alarm");
  chk_alarm_latch: assert property ((sequencer_clear_n [*8]) ##0 !protection_alarm_n
    |=> !protection_alarm_n) else $error("alarm dropped without clear");
  chk_hold_idle: assert property (
    ($stable({step_clock, sequencer_clear_n, enable, protection_alarm_n})) [*8]
    |-> $stable(wind)) else $error("windings moved with idle inputs");
  chk_step_moves: assert property (
    $rose(step_clock) && enable && sequencer_clear_n && protection_alarm_n
    |-> ##[3:10] !$stable(wind)) else $error("rising step edge not taken");
  chk_fall_ignored: assert property (
    $fell(step_clock) && edge_select && sequencer_clear_n && enable
    |=> $stable(wind) [*8])
    else $error("falling edge taken in rising-only mode");
  chk_clear_start: assert property (
    (fresh_reg && enable && protection_alarm_n) [*8] |-> wind == 4'h9)
    else $error("clear release not at start position");
  chk_enable_back: assert property (
    $rose(enable) && sequencer_clear_n && protection_alarm_n |-> ##[3:10] wind != 4'h0)
    else $error("outputs not restored after enable");
  chk_no_opposed: assert property (
    !(winding1_fwd && winding1_rev) && !(winding2_fwd && winding2_rev))
    else $error("both ends of one winding energised");

  cov_fault: cover property ($fell(protection_alarm_n));
  cov_enable: cover property ($rose(enable));
  cov_both_edges: cover property ($fell(step_clock) && !edge_select && enable);
  cov_half_rev: cover property ($rose(step_clock) && excitation_select && direction_select);
endmodule : stepper_props
`default_nettype wire

// *** testbench/stepper_phase_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module stepper_phase_sequencer_tb;
  import stepper_pkg::*;
  localparam logic [3:0] PAT [8] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'ha, 4'h8};
  logic       clk, reset_n, run, half_step, both_edges, reverse, power_good;
  logic       clear_request, overcurrent_detect, overheat_detect, in_fault, prev_step;
  logic       busy, alarm, fault_latched;
  logic [3:0] wind;
  logic [2:0] exp_pos;
  int         failures, cmp_count;

  stepper_if link ();
  stepper_phase_sequencer stepper_phase_sequencer_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .overcurrent_detect(overcurrent_detect), .overheat_detect(overheat_detect),
    .fault_latched(fault_latched));
  stepper_host #(.HALF_PERIOD_CYC(400)) stepper_host_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .run(run), .half_step(half_step), .both_edges(both_edges),
    .reverse(reverse), .power_good(power_good), .clear_request(clear_request),
    .busy(busy), .alarm(alarm));
  stepper_props stepper_props_inst (.clk(clk), .reset_n(reset_n),
    .step_clock(link.step_clock), .excitation_select(link.excitation_select),
    .edge_select(link.edge_select), .direction_select(link.direction_select),
    .sequencer_clear_n(link.sequencer_clear_n), .enable(link.enable),
    .winding1_fwd(link.winding1_fwd), .winding1_rev(link.winding1_rev),
    .winding2_fwd(link.winding2_fwd), .winding2_rev(link.winding2_rev),
    .protection_alarm_n(link.protection_alarm_n));

  assign wind = {link.winding2_rev, link.winding2_fwd, link.winding1_rev, link.winding1_fwd};
  always #25 clk = ~clk;

  // Reference position, taken from the wire levels at each counted edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exp_pos <= 3'h0;
      prev_step <= 1'b0;
    end else begin
      prev_step <= link.step_clock;
      if (!link.sequencer_clear_n) exp_pos <= 3'h0;
      else if (link.step_clock != prev_step && (link.step_clock || !link.edge_select)) begin
        if (link.excitation_select || exp_pos[0])
          exp_pos <= link.direction_select ? exp_pos - 3'h1 : exp_pos + 3'h1;
        else
          exp_pos <= link.direction_select ? exp_pos - 3'h2 : exp_pos + 3'h2;
      end
    end
  end

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic next_edge();
    logic s;
    int   n;
    s = link.step_clock;
    n = 0;
    while (link.step_clock === s && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) failures++;
  endtask : next_edge

  // Judge windings once the edge has had time to pass the input filter
  task automatic steps(input int n);
    repeat (n) begin
      next_edge();
      repeat (20) @(negedge clk);
      check("windings", wind, (power_good && !in_fault) ? PAT[exp_pos] : 4'h0);
    end
  endtask : steps

  task automatic t_clear();
    int n;
    clear_request = 1'b1;
    repeat (20) @(negedge clk);
    clear_request = 1'b0;
    in_fault = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) failures++;
    // Enable rises a cycle after busy drops and then crosses the input filter
    repeat (10) @(negedge clk);
    check("clear_start", wind, 4'h9);
    check("alarm_clear", {3'h0, link.protection_alarm_n}, 4'h1);
  endtask : t_clear

  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      {half_step, both_edges, reverse} = m[2:0];
      steps(5);
    end
  endtask : t_modes

  task automatic t_enable();
    power_good = 1'b0;
    steps(4);
    power_good = 1'b1;
    steps(3);
  endtask : t_enable

  // Run-out edges stretch to 1000 cycles, so 4000 covers them and leaves an idle tail
  task automatic t_hold();
    logic s;
    int   edges;
    s = link.step_clock;
    edges = 0;
    run = 1'b0;
    repeat (4000) begin
      @(negedge clk);
      if (link.step_clock !== s) edges++;
      s = link.step_clock;
    end
    check("ramp_edges", 4'(edges), 4'(RAMP_EDGES));
    check("hold", wind, PAT[exp_pos]);
    run = 1'b1;
  endtask : t_hold

  task automatic t_fault();
    for (int i = 0; i < 2; i++) begin
      next_edge();
      repeat (20) @(negedge clk);
      overcurrent_detect = (i == 0);
      overheat_detect = (i == 1);
      repeat (5) @(negedge clk);
      overcurrent_detect = 1'b0;
      overheat_detect = 1'b0;
      in_fault = 1'b1;
      repeat (20) @(negedge clk);
      check("fault", {alarm, fault_latched, link.protection_alarm_n, 1'b0}, 4'hc);
      steps(2);
      t_clear();
    end
  endtask : t_fault

  initial begin
    {clk, reset_n, run, half_step, both_edges, reverse, power_good} = 7'h0;
    {clear_request, overcurrent_detect, overheat_detect, in_fault} = 4'h0;
    failures = 0;
    cmp_count = 0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    check("por", wind, 4'h0);
    check("por_alarm", {2'h0, link.protection_alarm_n, fault_latched}, 4'h2);
    power_good = 1'b1;
    t_clear();
    run = 1'b1;
    t_modes();
    t_enable();
    t_hold();
    t_fault();
    close_out();
  end

  initial begin
    #2500000;
    failures++;
    close_out();
  end
endmodule : stepper_phase_sequencer_tb
`default_nettype wire
